// *** prs_hold_detect.sv ***
// module: one pulse once a button has been held for a fixed time
`timescale 1ns/1ps
module prs_hold_detect #(
  parameter int HOLD_CYCLES = 16
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic level,
  output logic      pulse
);

  logic [31:0] count_reg;
  logic        fired_reg;
  logic        pulse_reg;
  wire         reached = (count_reg == 32'(HOLD_CYCLES - 1));

  // one pulse per press: a held button must be released before it acts again
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_reg <= 32'h0000_0000;
      fired_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= level && reached && !fired_reg;
      if (!level) begin
        count_reg <= 32'h0000_0000;
        fired_reg <= 1'b0;
      end else if (reached) begin
        fired_reg <= 1'b1;
      end else begin
        count_reg <= count_reg + 32'h0000_0001;
      end
    end
  end

  assign pulse = pulse_reg;

  ////////////////////////////////////////////////////////////////////////////
  single_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
    pulse |=> !pulse) else $error("hold pulse longer than one cycle");

endmodule

// *** prs_pkg.sv ***
// package: constants and types shared by the pump run-state sequencer
package prs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int NS_PER_MS      = 1_000_000;
  localparam int HOLD_TIME_MS   = 1000;
  localparam int SPIN_DELAY_MS  = 3000;
  localparam int BLINK_HALF_MS  = 500;
  localparam int HOLD_CYCLES    = HOLD_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int SPIN_CYCLES    = SPIN_DELAY_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int BLINK_CYCLES   = BLINK_HALF_MS * (NS_PER_MS / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // speed thresholds
  localparam logic [15:0] REST_RPM          = 16'h003C;
  localparam logic [2:0]  AT_SPEED_NUM      = 3'h4;
  localparam logic [2:0]  AT_SPEED_DEN      = 3'h5;
  localparam logic [15:0] RATED_RPM_DEFAULT = 16'h7530;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam int          ADR_W      = 8;
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  RATED_OFS  = 8'h04;
  localparam logic [7:0]  CMD_OFS    = 8'h08;
  localparam logic [7:0]  STATUS_OFS = 8'h0C;
  localparam int          STD_CFG_BIT     = 0;
  localparam logic        STD_CFG_RESET   = 1'h1;
  localparam int          CMD_ONLINE_BIT  = 0;
  localparam int          CMD_OFFLINE_BIT = 1;
  localparam int          CMD_START_BIT   = 2;
  localparam int          CMD_STOP_BIT    = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reported codes
  localparam logic [1:0] CODE_HALTED   = 2'h0;
  localparam logic [1:0] CODE_SPIN_UP  = 2'h1;
  localparam logic [1:0] CODE_AT_SPEED = 2'h2;
  localparam logic [1:0] CODE_BRAKING  = 2'h3;
  localparam logic [1:0] CODE_CONTACT  = 2'h0;
  localparam logic [1:0] CODE_PANEL    = 2'h1;
  localparam logic [1:0] CODE_SERIAL   = 2'h2;

  typedef enum logic [1:0] {PRS_HALTED, PRS_SPIN_UP, PRS_AT_SPEED, PRS_BRAKING} prs_run_type;
  typedef enum logic [1:0] {PRS_MODE_CONTACT, PRS_MODE_PANEL, PRS_MODE_SERIAL} prs_mode_type;

endpackage

// *** prs_rotor_model.sv ***
// partner: rotor speed model that follows the reported run code
`timescale 1ns/1ps
module prs_rotor_model
  import prs_pkg::*;
#(
  parameter int STEP = 1000
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [1:0]  serial_status,
  output logic      [15:0] rotor_rpm
);
  ////////////////////////////////////////////////////////////////////////////
  // speed holds while halted: a coasting rotor does not snap to zero
  wire drive_up = (serial_status == CODE_SPIN_UP) || (serial_status == CODE_AT_SPEED);
  wire drive_dn = (serial_status == CODE_BRAKING);
  always_ff @(posedge core_clk) begin
    if (srst)
      rotor_rpm <= 16'h0000;
    else if (drive_up)
      rotor_rpm <= (rotor_rpm >= RATED_RPM_DEFAULT - 16'(STEP)) ? RATED_RPM_DEFAULT
                                                               : rotor_rpm + 16'(STEP);
    else if (drive_dn)
      rotor_rpm <= (rotor_rpm <= 16'(STEP)) ? 16'h0000 : rotor_rpm - 16'(STEP);
  end
endmodule

// *** prs_run_sequencer.sv ***
// module: run-state sequencer with mode selection, lamps, contacts and registers
`timescale 1ns/1ps
module prs_run_sequencer
  import prs_pkg::*;
#(
  parameter int HOLD_CYC  = HOLD_CYCLES,
  parameter int SPIN_CYC  = SPIN_CYCLES,
  parameter int BLINK_CYC = BLINK_CYCLES
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              wb_cyc,
  input  wire logic              wb_stb,
  input  wire logic              wb_we,
  input  wire logic [ADR_W-1:0]  wb_adr,
  input  wire logic [3:0]        wb_sel,
  input  wire logic [31:0]       wb_dat_w,
  output logic      [31:0]       wb_dat_r,
  output logic                   wb_ack,
  input  wire logic              mode_button,
  input  wire logic              run_button,
  input  wire logic              contact_start,
  input  wire logic              contact_stop,
  input  wire logic [15:0]       rotor_rpm,
  output logic                   power_lamp,
  output logic                   spin_lamp,
  output logic                   green_lamp,
  output logic                   remote_mode_out,
  output logic                   accel_out,
  output logic                   at_speed_out,
  output logic                   braking_state,
  output logic                   rotation_out,
  output logic      [1:0]        serial_status
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [31:0] prs_merge(input logic [31:0] old_val,
                                            input logic [31:0] new_val,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic prs_reached(input logic [15:0] rpm, input logic [15:0] rated);
    logic [18:0] lhs;
    logic [18:0] rhs;
    lhs = 19'(rpm) * 19'(AT_SPEED_DEN);
    rhs = 19'(rated) * 19'(AT_SPEED_NUM);
    return lhs >= rhs;
  endfunction

  function automatic logic [1:0] prs_run_code(input prs_run_type st);
    logic [1:0] code;
    code = CODE_HALTED;
    unique case (st)
      PRS_HALTED:   code = CODE_HALTED;
      PRS_SPIN_UP:  code = CODE_SPIN_UP;
      PRS_AT_SPEED: code = CODE_AT_SPEED;
      PRS_BRAKING:  code = CODE_BRAKING;
    endcase
    return code;
  endfunction

  function automatic logic [1:0] prs_mode_code(input prs_mode_type md);
    logic [1:0] code;
    code = CODE_CONTACT;
    unique case (md)
      PRS_MODE_CONTACT: code = CODE_CONTACT;
      PRS_MODE_PANEL:   code = CODE_PANEL;
      PRS_MODE_SERIAL:  code = CODE_SERIAL;
      default:          code = CODE_CONTACT;
    endcase
    return code;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  prs_run_type  state_reg;
  prs_run_type  state_next;
  prs_mode_type mode_reg;
  prs_mode_type mode_next;
  logic         ack_reg;
  logic [31:0]  dat_r_reg;
  logic         std_cfg_reg;
  logic [15:0]  rated_reg;
  logic         cmd_online_reg;
  logic         cmd_offline_reg;
  logic         cmd_start_reg;
  logic         cmd_stop_reg;
  logic [31:0]  spin_cnt_reg;
  logic [31:0]  blink_cnt_reg;
  logic         blink_reg;
  logic         power_lamp_reg;
  logic         spin_lamp_reg;
  logic         green_lamp_reg;
  logic         remote_mode_reg;
  logic         accel_reg;
  logic         at_speed_reg;
  logic         braking_reg;
  logic         rotation_reg;
  logic [1:0]   serial_status_reg;
  logic         mode_hold;
  logic         run_hold;

  ////////////////////////////////////////////////////////////////////////////
  // button hold detection

  prs_hold_detect #(.HOLD_CYCLES(HOLD_CYC)) u_mode_hold (
    .core_clk (core_clk),
    .srst     (srst),
    .level    (mode_button),
    .pulse    (mode_hold)
  );

  prs_hold_detect #(.HOLD_CYCLES(HOLD_CYC)) u_run_hold (
    .core_clk (core_clk),
    .srst     (srst),
    .level    (run_button),
    .pulse    (run_hold)
  );

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the request, writes land on the ack edge

  wire        wb_req    = wb_cyc && wb_stb;
  wire        wr_take   = wb_req && wb_we && ack_reg;
  wire        hit_ctrl  = (wb_adr == CTRL_OFS);
  wire        hit_rated = (wb_adr == RATED_OFS);
  wire        hit_cmd   = (wb_adr == CMD_OFS);
  wire        hit_stat  = (wb_adr == STATUS_OFS);
  wire [31:0] ctrl_merged  = prs_merge({31'h0000_0000, std_cfg_reg}, wb_dat_w, wb_sel);
  wire [31:0] rated_merged = prs_merge({16'h0000, rated_reg}, wb_dat_w, wb_sel);
  wire        cmd_wr    = wr_take && hit_cmd && wb_sel[0];
  wire [31:0] status_word = {rotor_rpm, 11'h000, rotation_reg,
                             prs_mode_code(mode_reg), prs_run_code(state_reg)};
  wire [31:0] read_mux  = hit_ctrl  ? {31'h0000_0000, std_cfg_reg} :
                          hit_rated ? {16'h0000, rated_reg} :
                          hit_stat  ? status_word : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_reg   <= 1'b0;
      dat_r_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req && !ack_reg;
      if (wb_req && !ack_reg) begin
        dat_r_reg <= read_mux;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      std_cfg_reg <= STD_CFG_RESET;
      rated_reg   <= RATED_RPM_DEFAULT;
    end else begin
      if (wr_take && hit_ctrl) begin
        std_cfg_reg <= ctrl_merged[STD_CFG_BIT];
      end
      if (wr_take && hit_rated) begin
        rated_reg <= rated_merged[15:0];
      end
    end
  end

  // serial link commands: one-cycle pulses, the write strobe is the event
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_online_reg  <= 1'b0;
      cmd_offline_reg <= 1'b0;
      cmd_start_reg   <= 1'b0;
      cmd_stop_reg    <= 1'b0;
    end else begin
      cmd_online_reg  <= cmd_wr && wb_dat_w[CMD_ONLINE_BIT];
      cmd_offline_reg <= cmd_wr && wb_dat_w[CMD_OFFLINE_BIT];
      cmd_start_reg   <= cmd_wr && wb_dat_w[CMD_START_BIT];
      cmd_stop_reg    <= cmd_wr && wb_dat_w[CMD_STOP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection and mode

  wire in_contact = (mode_reg == PRS_MODE_CONTACT);
  wire in_panel   = (mode_reg == PRS_MODE_PANEL);
  wire in_serial  = (mode_reg == PRS_MODE_SERIAL);
  wire running    = (state_reg == PRS_SPIN_UP) || (state_reg == PRS_AT_SPEED);
  // only the selected source reaches the run state; a level held on both
  // contacts is treated as stop so a stuck start cannot restart the rotor
  wire src_start  = (in_panel && run_hold && state_reg == PRS_HALTED) ||
                    (in_contact && contact_start && !contact_stop) ||
                    (in_serial && cmd_start_reg);
  wire src_stop   = (in_panel && run_hold && running) ||
                    (in_contact && contact_stop) ||
                    (in_serial && cmd_stop_reg);
  wire at_80      = prs_reached(rotor_rpm, rated_reg);
  wire at_rest    = (rotor_rpm <= REST_RPM);

  always_comb begin
    mode_next = mode_reg;
    if (cmd_online_reg) begin
      mode_next = PRS_MODE_SERIAL;
    end else if (in_serial && cmd_offline_reg) begin
      mode_next = PRS_MODE_CONTACT;
    end else if (in_contact && mode_hold) begin
      mode_next = PRS_MODE_PANEL;
    end else if (in_panel && mode_hold) begin
      mode_next = PRS_MODE_CONTACT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run state

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PRS_HALTED: begin
        if (src_start) begin
          state_next = PRS_SPIN_UP;
        end
      end
      PRS_SPIN_UP: begin
        if (src_stop) begin
          state_next = PRS_BRAKING;
        end else if (at_80) begin
          state_next = PRS_AT_SPEED;
        end
      end
      PRS_AT_SPEED: begin
        if (src_stop) begin
          state_next = PRS_BRAKING;
        end
      end
      PRS_BRAKING: begin
        if (at_rest) begin
          state_next = PRS_HALTED;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= PRS_HALTED;
      mode_reg  <= PRS_MODE_CONTACT;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timers: rotation delay and lamp blink

  wire spin_done  = (spin_cnt_reg == 32'(SPIN_CYC));
  wire blink_wrap = (blink_cnt_reg == 32'(BLINK_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (srst) begin
      spin_cnt_reg  <= 32'h0000_0000;
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= 1'b0;
    end else begin
      if (state_next == PRS_HALTED) begin
        spin_cnt_reg <= 32'h0000_0000;
      end else if (!spin_done) begin
        spin_cnt_reg <= spin_cnt_reg + 32'h0000_0001;
      end
      blink_cnt_reg <= blink_wrap ? 32'h0000_0000 : blink_cnt_reg + 32'h0000_0001;
      if (blink_wrap) begin
        blink_reg <= !blink_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicators, registered from the next state so they move with it

  wire std_cfg = std_cfg_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      power_lamp_reg    <= 1'b1;
      spin_lamp_reg     <= 1'b0;
      green_lamp_reg    <= 1'b0;
      remote_mode_reg   <= STD_CFG_RESET;
      accel_reg         <= 1'b0;
      at_speed_reg      <= 1'b0;
      braking_reg       <= 1'b0;
      rotation_reg      <= 1'b0;
      serial_status_reg <= CODE_HALTED;
    end else begin
      power_lamp_reg    <= (mode_next == PRS_MODE_PANEL) ? blink_reg : 1'b1;
      spin_lamp_reg     <= (state_next != PRS_HALTED);
      green_lamp_reg    <= (state_next == PRS_AT_SPEED) ||
                           (state_next == PRS_SPIN_UP && blink_reg);
      remote_mode_reg   <= std_cfg && (mode_next == PRS_MODE_CONTACT);
      accel_reg         <= std_cfg && (state_next == PRS_SPIN_UP);
      at_speed_reg      <= (state_next == PRS_AT_SPEED);
      braking_reg       <= std_cfg && (state_next == PRS_BRAKING);
      rotation_reg      <= (state_next != PRS_HALTED) && spin_done;
      serial_status_reg <= prs_run_code(state_next);
    end
  end

  assign wb_ack          = ack_reg;
  assign wb_dat_r        = dat_r_reg;
  assign power_lamp      = power_lamp_reg;
  assign spin_lamp       = spin_lamp_reg;
  assign green_lamp      = green_lamp_reg;
  assign remote_mode_out = remote_mode_reg;
  assign accel_out       = accel_reg;
  assign at_speed_out    = at_speed_reg;
  assign braking_state   = braking_reg;
  assign rotation_out    = rotation_reg;
  assign serial_status   = serial_status_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  reset_contact_a: assert property (@(posedge core_clk)
    srst |=> (mode_reg == PRS_MODE_CONTACT && state_reg == PRS_HALTED))
    else $error("reset did not enter contact mode halted");

  panel_enter_a: assert property (@(posedge core_clk) disable iff (srst)
    (in_contact && mode_hold && !cmd_online_reg) |=> in_panel)
    else $error("held mode button did not enter panel mode");

  power_steady_a: assert property (@(posedge core_clk) disable iff (srst)
    !in_panel |-> power_lamp)
    else $error("power lamp not steady outside panel mode");

  remote_flag_a: assert property (@(posedge core_clk) disable iff (srst)
    (in_contact && std_cfg_reg && $stable(std_cfg_reg)) |-> remote_mode_out)
    else $error("remote-mode output missing in contact mode");

  online_mode_a: assert property (@(posedge core_clk) disable iff (srst)
    cmd_online_reg |=> (in_serial && status_word[3:2] == CODE_SERIAL))
    else $error("online request did not show serial mode");

  offline_mode_a: assert property (@(posedge core_clk) disable iff (srst)
    (in_serial && cmd_offline_reg && !cmd_online_reg) |=> in_contact)
    else $error("offline request did not return to contact mode");

  contact_start_a: assert property (@(posedge core_clk) disable iff (srst)
    (in_contact && state_reg == PRS_HALTED && contact_start && !contact_stop)
    |=> (state_reg == PRS_SPIN_UP && accel_out == std_cfg_reg && spin_lamp))
    else $error("contact start did not begin spin-up");

  rotation_late_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == PRS_HALTED ##1 state_reg == PRS_SPIN_UP) |-> !rotation_out ##1 !rotation_out)
    else $error("rotation output rose at spin-up start");

  speed_reach_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == PRS_SPIN_UP && at_80 && !src_stop)
    |=> (at_speed_out && !accel_out && serial_status == CODE_AT_SPEED))
    else $error("80 percent speed not reported together");

  green_steady_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == PRS_AT_SPEED) |-> green_lamp)
    else $error("green lamp not steady at speed");

  green_off_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == PRS_BRAKING || state_reg == PRS_HALTED) |-> !green_lamp)
    else $error("green lamp lit while braking or halted");

  serial_stop_a: assert property (@(posedge core_clk) disable iff (srst)
    (in_serial && cmd_stop_reg && running)
    |=> (state_reg == PRS_BRAKING && serial_status == CODE_BRAKING))
    else $error("serial stop did not report braking");

  rest_halt_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == PRS_BRAKING && at_rest)
    |=> (!spin_lamp && !rotation_out && !braking_state && serial_status == CODE_HALTED))
    else $error("rest speed did not halt all indicators");

  foreign_src_a: assert property (@(posedge core_clk) disable iff (srst)
    (in_serial && state_reg == PRS_HALTED && !cmd_start_reg) |=> state_reg == PRS_HALTED)
    else $error("start taken from an unselected source");

endmodule

// *** tb.sv ***
// testbench: contact, panel and command-register run sequences
`timescale 1ns/1ps
module tb;
  import prs_pkg::*;
  logic        core_clk = 0, srst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0;
  logic [7:0]  wb_adr = 0;
  logic [3:0]  wb_sel = 4'hF;
  logic [31:0] wb_dat_w = 0, wb_dat_r, rd;
  logic        wb_ack, mode_button = 0, run_button = 0, contact_start = 0, contact_stop = 0;
  logic        power_lamp, spin_lamp, green_lamp, remote_mode_out, accel_out;
  logic        at_speed_out, braking_state, rotation_out;
  logic [1:0]  serial_status;
  logic [15:0] rotor_rpm;
  int          num_errors = 0, samples_checked = 0, c, n;

  always #5 core_clk = ~core_clk;

  prs_run_sequencer #(.HOLD_CYC(4), .SPIN_CYC(8), .BLINK_CYC(3)) DUT (.core_clk, .srst,
    .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .mode_button,
    .run_button, .contact_start, .contact_stop, .rotor_rpm, .power_lamp, .spin_lamp,
    .green_lamp, .remote_mode_out, .accel_out, .at_speed_out, .braking_state,
    .rotation_out, .serial_status);
  prs_rotor_model rotor (.core_clk, .srst, .serial_status, .rotor_rpm);

  ////////////////////////////////////////////////////////////////////////////
  task tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until ack is sampled, then released for one idle cycle;
  // only the watchdog ends a wait for an answer that never comes
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      tick(1);
    end while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 0;
    wb_stb <= 0;
    wb_we <= 0;
    tick(1);
    chk("wb_ack_drop", 0, wb_ack);
  endtask
  task cmd(input int b);
    wb(1, CMD_OFS, 32'h1 << b);
    tick(1);
  endtask
  task wcode(input logic [1:0] s);
    n = 0;
    while (serial_status !== s && n < 300) begin
      tick(1);
      n++;
    end
    chk("wait_code", s, serial_status);
  endtask
  task press(input bit run);
    if (run) run_button <= 1;
    else mode_button <= 1;
    tick(6);
    run_button <= 0;
    mode_button <= 0;
    tick(3);
  endtask
  task pulse(input bit stop);
    if (stop) contact_stop <= 1;
    else contact_start <= 1;
    tick(1);
    contact_start <= 0;
    contact_stop <= 0;
    tick(1);
  endtask
  // counts level changes of a lamp over eight cycles
  task toggles(input bit green);
    logic p;
    c = 0;
    repeat (8) begin
      p = green ? green_lamp : power_lamp;
      tick(1);
      c += ((green ? green_lamp : power_lamp) !== p);
    end
  endtask
  task done(input string nm);
    $display("test %s finished", nm);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(12);
    srst <= 0;
    tick(2);
    chk("power_lamp", 1, power_lamp);
    chk("remote_mode_out", 1, remote_mode_out);
    wb(0, CTRL_OFS, 0);
    chk("ctrl", 1, rd);
    wb(0, RATED_OFS, 0);
    chk("rated", RATED_RPM_DEFAULT, rd);
    wb(0, 8'h10, 0);
    chk("unmapped", 0, rd);
    wb(0, STATUS_OFS, 0);
    chk("mode", CODE_CONTACT, rd[3:2]);
    wb(1, CTRL_OFS, 0);
    tick(2);
    chk("remote_cfg_off", 0, remote_mode_out);
    wb(1, CTRL_OFS, 1);
    press(1);
    chk("run_button_ignored", CODE_HALTED, serial_status);
    done("reset");
    pulse(0);
    chk("accel_out", 1, accel_out);
    chk("rotation_early", 0, rotation_out);
    n = 0;
    while (rotation_out !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    chk("rotation_delay", 1, n >= 5 && n <= 9);
    wcode(CODE_AT_SPEED);
    chk("accel_off", 0, accel_out);
    chk("at_speed_out", 1, at_speed_out);
    chk("rpm_at_80pct", 1, rotor_rpm >= 16'h5DC0 && rotor_rpm <= 16'h6590);
    pulse(1);
    chk("braking_state", 1, braking_state);
    chk("at_speed_off", 0, at_speed_out);
    wcode(CODE_HALTED);
    chk("rotation_off", 0, rotation_out);
    chk("braking_off", 0, braking_state);
    chk("rpm_rest", 1, rotor_rpm <= REST_RPM);
    done("contact");
    press(0);
    wb(0, STATUS_OFS, 0);
    chk("mode", CODE_PANEL, rd[3:2]);
    toggles(0);
    chk("power_blink", 1, c >= 2);
    pulse(0);
    chk("contact_ignored", CODE_HALTED, serial_status);
    press(1);
    chk("spin_lamp", 1, spin_lamp);
    toggles(1);
    chk("green_blink", 1, c >= 1);
    wcode(CODE_AT_SPEED);
    toggles(1);
    chk("green_steady", 1, c == 0 && green_lamp === 1'b1);
    press(1);
    chk("green_off", 0, green_lamp);
    chk("panel_stop", CODE_BRAKING, serial_status);
    wcode(CODE_HALTED);
    chk("spin_lamp_off", 0, spin_lamp);
    press(0);
    wb(0, STATUS_OFS, 0);
    chk("mode_back", CODE_CONTACT, rd[3:2]);
    chk("power_steady", 1, power_lamp);
    done("panel");
    cmd(CMD_ONLINE_BIT);
    wb(0, STATUS_OFS, 0);
    chk("mode", CODE_SERIAL, rd[3:2]);
    pulse(0);
    chk("contact_in_serial", CODE_HALTED, serial_status);
    cmd(CMD_START_BIT);
    chk("code_start", CODE_SPIN_UP, serial_status);
    wcode(CODE_AT_SPEED);
    cmd(CMD_STOP_BIT);
    chk("stop_at_speed", CODE_BRAKING, serial_status);
    wcode(CODE_HALTED);
    cmd(CMD_START_BIT);
    cmd(CMD_STOP_BIT);
    chk("stop_spin_up", CODE_BRAKING, serial_status);
    wcode(CODE_HALTED);
    cmd(CMD_OFFLINE_BIT);
    wb(0, STATUS_OFS, 0);
    chk("mode", CODE_CONTACT, rd[3:2]);
    cmd(CMD_ONLINE_BIT);
    cmd(CMD_START_BIT);
    wcode(CODE_AT_SPEED);
    srst <= 1;
    tick(2);
    srst <= 0;
    tick(2);
    chk("reset_code", CODE_HALTED, serial_status);
    chk("reset_remote", 1, remote_mode_out);
    wb(0, STATUS_OFS, 0);
    chk("mode", CODE_CONTACT, rd[3:2]);
    done("serial");
    conclude;
  end

  initial begin
    tick(20000);
    num_errors++;
    conclude;
  end
endmodule
